// File: shared/xio_pkg.sv
// package: register map, field positions and codes for the extension io block
package xio_pkg;
  // register offsets (word index on the plain register port)
  localparam logic [3:0] XIO_OFS_IN_LEVELS = 4'h0;
  localparam logic [3:0] XIO_OFS_OUT_LEVELS = 4'h1;
  localparam logic [3:0] XIO_OFS_OVR_SEL = 4'h2;
  localparam logic [3:0] XIO_OFS_OVR_VAL = 4'h3;
  localparam logic [3:0] XIO_OFS_SRC_A = 4'h4;
  localparam logic [3:0] XIO_OFS_SRC_B = 4'h5;
  localparam logic [3:0] XIO_OFS_DOUT_CTL = 4'h6;
  // field positions in output words
  localparam int XIO_BIT_RELAY_A = 0;
  localparam int XIO_BIT_RELAY_B = 1;
  localparam int XIO_BIT_DOUT = 5;
  // writable bits of override words
  localparam logic [15:0] XIO_OVR_MASK = 16'h0023;
  // reset values
  localparam logic [15:0] XIO_OVR_RST = 16'h0000;
  localparam logic [4:0] XIO_SRC_RST = 5'h00;
  // status word bit positions
  localparam int XIO_MAIN_READY_RUN = 1;
  localparam int XIO_MAIN_READY_REF = 2;
  localparam int XIO_MAIN_AT_TARGET = 8;
  localparam int XIO_DRV1_ENABLED = 0;
  localparam int XIO_DRV1_STARTED = 5;
  localparam int XIO_DRV1_RUNNING = 6;
  localparam int XIO_DRV2_MAGNETIZED = 1;
  localparam int XIO_SPD_REVERSE = 2;
  // relay source selector codes
  typedef enum logic [4:0] {
    XIO_SRC_OFF = 5'h00,
    XIO_SRC_ON = 5'h01,
    XIO_SRC_READY_RUN = 5'h02,
    XIO_SRC_ENABLED = 5'h04,
    XIO_SRC_STARTED = 5'h05,
    XIO_SRC_MAGNETIZED = 5'h06,
    XIO_SRC_RUNNING = 5'h07,
    XIO_SRC_READY_REF = 5'h08,
    XIO_SRC_AT_TARGET = 5'h09,
    XIO_SRC_REVERSE = 5'h0A
  } xio_src_t;
endpackage

// File: rtl/xio_relay_src.sv
// relay source selector: maps a selector code to a status bit
`timescale 1ns/1ps
module xio_relay_src (
  // selection
  input wire logic [4:0] sel_i,
  // status words
  input wire logic [15:0] main_status_i,
  input wire logic [15:0] drive_status1_i,
  input wire logic [15:0] drive_status2_i,
  input wire logic [15:0] speed_status_i,
  // result
  output logic level_o
);
  import xio_pkg::*;

  // combinational pick of the source bit
  always_comb begin
    unique case (sel_i)
      XIO_SRC_OFF: level_o = 1'b0;
      XIO_SRC_ON: level_o = 1'b1;
      XIO_SRC_READY_RUN: level_o = main_status_i[XIO_MAIN_READY_RUN];
      XIO_SRC_READY_REF: level_o = main_status_i[XIO_MAIN_READY_REF];
      XIO_SRC_AT_TARGET: level_o = main_status_i[XIO_MAIN_AT_TARGET];
      XIO_SRC_ENABLED: level_o = drive_status1_i[XIO_DRV1_ENABLED];
      XIO_SRC_STARTED: level_o = drive_status1_i[XIO_DRV1_STARTED];
      XIO_SRC_RUNNING: level_o = drive_status1_i[XIO_DRV1_RUNNING];
      XIO_SRC_MAGNETIZED: level_o = drive_status2_i[XIO_DRV2_MAGNETIZED];
      XIO_SRC_REVERSE: level_o = speed_status_i[XIO_SPD_REVERSE];
      default: level_o = 1'b0; // unlisted codes keep the relay off
    endcase
  end
endmodule

// File: rtl/xio_top.sv
// extension io status and output override block
// behaviour notes
// - one clock, one synchronous active-high reset, no enables needed
// - every output is a flop, so outputs lag the status words by one cycle
// - a write lands at its strobe edge; the outputs follow one edge later
// - read data stand only in the cycle after the read strobe, else zero
// - reads have no side effects, so back-to-back strobes are safe
// - the input and output status words have no write path at all
// - the output status word shows the driven levels, not the requests
// - override words keep only bits 0, 1 and 5; other bits read zero
// - the force select gates the forced value; a value alone does nothing
// - a cleared select bit hands the output back to its normal source
// - reset clears both override words and parks both relays on code zero
// - unlisted selector codes hold the relay off rather than let it float
// - selector codes are stored as written, unlisted ones included
// - digital out has no selector; its normal level is a plain register bit
// - inputs are taken as synchronous; no synchroniser sits in front
// - the status words from the drive are levels, sampled every cycle
// - a status bit that pulses for less than a cycle may be missed
//
// register index map
// - 0: input levels, read only
// - 1: output levels, read only
// - 2: override select mask
// - 3: override values
// - 4: relay a source code
// - 5: relay b source code
// - 6: digital out normal level in bit 0
// - 7 and up: unmapped, read zero, writes dropped
//
// hazards for users
// - forcing an output and clearing the force takes two writes
// - write the value word before the select word to avoid a glitch
// - selecting first drives the old value for one cycle
// - a relay source change takes effect on the next cycle
// - the relay flops do not debounce; a fast status toggles the relay
// - nothing here limits how often a relay may switch
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module xio_top #(
  parameter int NUM_INPUTS = 6 // extension input count
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // extension inputs
  input wire logic [NUM_INPUTS-1:0] ext_input_i,
  // drive status words
  input wire logic [15:0] main_status_i,
  input wire logic [15:0] drive_status1_i,
  input wire logic [15:0] drive_status2_i,
  input wire logic [15:0] speed_status_i,
  // outputs to the module
  output logic relay_out_a_o,
  output logic relay_out_b_o,
  output logic ext_digital_out_o
);
  import xio_pkg::*;

  // software registers
  logic [15:0] ovr_sel_r; // override select mask
  logic [15:0] ovr_val_r; // override values
  logic [4:0] src_a_r; // relay a source code
  logic [4:0] src_b_r; // relay b source code
  logic dout_ctl_r; // digital out normal level
  logic [NUM_INPUTS-1:0] in_r; // sampled inputs

  // output and read flops
  logic relay_a_r; // relay a level as driven
  logic relay_b_r; // relay b level as driven
  logic dout_r; // digital out level as driven
  logic [15:0] rdata_r; // read data, one cycle only

  // write hit on one register index
  // the read-only indices never get a hit, so writes there fall away
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] ofs);
    return wr && (addr == ofs);
  endfunction

  // forced value wins while the select bit stands, else the normal level
  // the value bit alone never reaches the output
  function automatic logic ovr_pick(input logic [15:0] sel, input logic [15:0] val, input int pos,
    input logic normal);
    return sel[pos] ? val[pos] : normal;
  endfunction

  // zero-extend a selector code to a read word
  function automatic logic [15:0] rd_word5(input logic [4:0] f);
    return {11'h000, f};
  endfunction

  // write decode, one named wire per writable register
  wire wr_sel = wr_hit(reg_wr_i, reg_addr_i, XIO_OFS_OVR_SEL); // override select
  wire wr_val = wr_hit(reg_wr_i, reg_addr_i, XIO_OFS_OVR_VAL); // override values
  wire wr_src_a = wr_hit(reg_wr_i, reg_addr_i, XIO_OFS_SRC_A); // relay a source code
  wire wr_src_b = wr_hit(reg_wr_i, reg_addr_i, XIO_OFS_SRC_B); // relay b source code
  wire wr_dout = wr_hit(reg_wr_i, reg_addr_i, XIO_OFS_DOUT_CTL); // digital out level
  // no decode wire exists for indices 0 and 1: the status words
  // cannot be written, whatever the strobe carries

  // normal sources
  logic src_a_lvl;
  logic src_b_lvl;

  xio_relay_src u_src_a (
    .sel_i(src_a_r),
    .main_status_i(main_status_i),
    .drive_status1_i(drive_status1_i),
    .drive_status2_i(drive_status2_i),
    .speed_status_i(speed_status_i),
    .level_o(src_a_lvl)
  );

  xio_relay_src u_src_b (
    .sel_i(src_b_r),
    .main_status_i(main_status_i),
    .drive_status1_i(drive_status1_i),
    .drive_status2_i(drive_status2_i),
    .speed_status_i(speed_status_i),
    .level_o(src_b_lvl)
  );

  // override muxes, only while the select bit stands
  // reserved bits of either word never reach a mux
  wire relay_a_nxt = ovr_pick(ovr_sel_r, ovr_val_r, XIO_BIT_RELAY_A, src_a_lvl);
  wire relay_b_nxt = ovr_pick(ovr_sel_r, ovr_val_r, XIO_BIT_RELAY_B, src_b_lvl);
  wire dout_nxt = ovr_pick(ovr_sel_r, ovr_val_r, XIO_BIT_DOUT, dout_ctl_r);

  // input status word, first input in bit 0, upper bits zero
  wire [15:0] in_word = 16'(in_r);

  // output status word built from the driven levels, not the requests
  logic [15:0] out_word;
  always_comb begin
    out_word = 16'h0000; // unused bits read zero
    out_word[XIO_BIT_RELAY_A] = relay_a_r;
    out_word[XIO_BIT_RELAY_B] = relay_b_r;
    out_word[XIO_BIT_DOUT] = dout_r;
  end

  // short fields widened for readback
  wire [15:0] src_a_word = rd_word5(src_a_r); // relay a code
  wire [15:0] src_b_word = rd_word5(src_b_r); // relay b code
  wire [15:0] dout_word = {15'h0000, dout_ctl_r}; // digital out level

  // read mux, picked on the strobe cycle and held by the read flop
  logic [15:0] rdata_nxt;
  always_comb begin
    unique case (reg_addr_i)
      XIO_OFS_IN_LEVELS: rdata_nxt = in_word; // input levels
      XIO_OFS_OUT_LEVELS: rdata_nxt = out_word; // output levels
      XIO_OFS_OVR_SEL: rdata_nxt = ovr_sel_r; // select mask
      XIO_OFS_OVR_VAL: rdata_nxt = ovr_val_r; // forced values
      XIO_OFS_SRC_A: rdata_nxt = src_a_word; // relay a code
      XIO_OFS_SRC_B: rdata_nxt = src_b_word; // relay b code
      XIO_OFS_DOUT_CTL: rdata_nxt = dout_word; // digital out level
      default: rdata_nxt = 16'h0000; // unmapped reads zero
    endcase
  end

  // override select mask; reserved bits are never stored
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ovr_sel_r <= XIO_OVR_RST;
    end else if (wr_sel) begin
      ovr_sel_r <= reg_wdata_i & XIO_OVR_MASK;
    end
  end

  // override values; reserved bits are never stored
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ovr_val_r <= XIO_OVR_RST;
    end else if (wr_val) begin
      ovr_val_r <= reg_wdata_i & XIO_OVR_MASK;
    end
  end

  // relay a source code; reset parks it on the off code
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      src_a_r <= XIO_SRC_RST;
    end else if (wr_src_a) begin
      src_a_r <= reg_wdata_i[4:0]; // any code; unlisted ones act as off
    end
  end

  // relay b source code; reset parks it on the off code
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      src_b_r <= XIO_SRC_RST;
    end else if (wr_src_b) begin
      src_b_r <= reg_wdata_i[4:0]; // any code; unlisted ones act as off
    end
  end

  // digital out normal level, used while not forced
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dout_ctl_r <= 1'b0; // off after reset
    end else if (wr_dout) begin
      dout_ctl_r <= reg_wdata_i[0]; // bit 0 only
    end
  end

  // input sample flop; only the pins load it, never the register port
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_r <= '0; // inputs read off during reset
    end else begin
      in_r <= ext_input_i;
    end
  end

  // relay a flop follows its mux every cycle, so a released force ends one edge after the select write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      relay_a_r <= 1'b0; // de-energised after reset
    end else begin
      relay_a_r <= relay_a_nxt;
    end
  end

  // relay b flop follows its mux every cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      relay_b_r <= 1'b0; // de-energised after reset
    end else begin
      relay_b_r <= relay_b_nxt;
    end
  end

  // digital out flop; no write path, so the status word always tracks it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dout_r <= 1'b0; // off after reset
    end else begin
      dout_r <= dout_nxt;
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = rdata_r;
  assign relay_out_a_o = relay_a_r;
  assign relay_out_b_o = relay_b_r;
  assign ext_digital_out_o = dout_r;
endmodule

// File: testbench/xio_top_asserts.sv
// checker: port-level properties of the extension io block
`timescale 1ns/1ps
module xio_top_asserts import xio_pkg::*; #(
  parameter int NUM_INPUTS = 6 // extension input count
) (
  // clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // levels in and out
  input wire logic [NUM_INPUTS-1:0] ext_input_i,
  input wire logic [15:0] main_status_i,
  input wire logic [15:0] drive_status1_i,
  input wire logic [15:0] drive_status2_i,
  input wire logic [15:0] speed_status_i,
  input wire logic relay_out_a_o,
  input wire logic relay_out_b_o,
  input wire logic ext_digital_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // outputs placed as in the output word
  wire logic [15:0] ow = {10'h000, ext_digital_out_o, 3'h0, relay_out_b_o, relay_out_a_o};
  // all status words side by side
  wire logic [63:0] stat = {main_status_i, drive_status1_i, drive_status2_i, speed_status_i};
  property p_inlv; reg_rd_i && reg_addr_i == 4'h0 && !$past(rst_i) |=> reg_rdata_o == 16'($past(ext_input_i, 2)); endproperty
  a_inlv: assert property (p_inlv) else $error("input word wrong");
  property p_outlv; reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o == $past(ow); endproperty
  a_outlv: assert property (p_outlv) else $error("output word wrong");
  property p_unmap; reg_rd_i && reg_addr_i > 4'h6 |=> reg_rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rb; reg_wr_i && reg_addr_i == 4'h2 ##1 reg_rd_i && reg_addr_i == 4'h2 |=>
    reg_rdata_o == ($past(reg_wdata_i, 2) & XIO_OVR_MASK); endproperty
  a_rb: assert property (p_rb) else $error("select readback wrong");
  property p_rst; $fell(rst_i) |-> ow == 16'h0000 && reg_rdata_o == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("not cleared by reset");
  property p_hold; !$past(reg_wr_i, 2) && $past(stat) == $past(stat, 2) |-> $stable(ow); endproperty
  a_hold: assert property (p_hold) else $error("output moved without cause");
  property p_force; reg_wr_i && reg_addr_i == 4'h3 ##1 reg_wr_i && reg_addr_i == 4'h2 |=>
    ##1 ((ow ^ $past(reg_wdata_i, 3)) & $past(reg_wdata_i, 2) & XIO_OVR_MASK) == 16'h0000; endproperty
  a_force: assert property (p_force) else $error("forced output wrong");
  property p_src; reg_wr_i && reg_addr_i == 4'h2 && reg_wdata_i == 16'h0000 ##1 reg_wr_i && reg_addr_i == 4'h4
    && reg_wdata_i < 16'h0002 |=> ##1 relay_out_a_o == $past(reg_wdata_i[0], 2); endproperty
  a_src: assert property (p_src) else $error("constant source wrong");
endmodule

// File: testbench/xio_top_bench.sv
// bench: register, override and source selection checks
`timescale 1ns/1ps
module xio_top_bench;
  import xio_pkg::*;
  logic sys_clk_i = 1'b0; // clock
  logic rst_i = 1'b1; // reset
  logic [3:0] reg_addr_i = 4'h0; // register index
  logic [15:0] reg_wdata_i = 16'h0000; // write data
  logic reg_wr_i = 1'b0; // write strobe
  logic reg_rd_i = 1'b0; // read strobe
  logic [15:0] reg_rdata_o; // read data
  logic [5:0] ext_input_i = 6'h00; // input levels
  logic [15:0] ms = 16'h0000, d1 = 16'h0000, d2 = 16'h0000, sp = 16'h0000; // status words
  logic ra, rb, dout; // outputs
  logic [15:0] seed = 16'h13FC, v, s; // stimulus state
  int errors = 0, cmp_count = 0; // tallies
  logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A};
  xio_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ext_input_i(ext_input_i),
    .main_status_i(ms), .drive_status1_i(d1), .drive_status2_i(d2), .speed_status_i(sp),
    .relay_out_a_o(ra), .relay_out_b_o(rb), .ext_digital_out_o(dout));
  always #5 sys_clk_i = ~sys_clk_i; // 100 MHz
  // linear feedback shift register step
  function logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // expected relay level for a selector code
  function logic src(input logic [4:0] c);
    case (c)
      5'h01: return 1'b1;
      5'h02: return ms[1];
      5'h04: return d1[0];
      5'h05: return d1[5];
      5'h06: return d2[1];
      5'h07: return d1[6];
      5'h08: return ms[2];
      5'h09: return ms[8];
      5'h0A: return sp[2];
      default: return 1'b0;
    endcase
  endfunction
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task idle(input int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
  endtask
  // read, check the data in the following cycle
  task rd(input logic [3:0] a, input logic [15:0] x);
    reg_addr_i <= a;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 chk("rdata", x, reg_rdata_o);
    idle(1);
  endtask
  task summarize();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    idle(1);
    chk("outputs", 16'h0000, {10'h000, dout, 3'h0, rb, ra});
    rd(XIO_OFS_OVR_VAL, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    // forced values over random masks, all bits set first
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      s = (i == 0) ? 16'hFFFF : rnd();
      ext_input_i <= v[5:0];
      wr(XIO_OFS_OVR_VAL, v);
      wr(XIO_OFS_OVR_SEL, s);
      rd(XIO_OFS_OVR_SEL, s & XIO_OVR_MASK);
      chk("outputs", s & v & XIO_OVR_MASK, {10'h000, dout, 3'h0, rb, ra});
      wr(XIO_OFS_OUT_LEVELS, ~v);
      rd(XIO_OFS_OUT_LEVELS, s & v & XIO_OVR_MASK);
      wr(XIO_OFS_IN_LEVELS, ~v);
      rd(XIO_OFS_IN_LEVELS, {10'h000, v[5:0]});
    end
    // reset in mid-run while forces stand
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(2);
    chk("outputs", 16'h0000, {10'h000, dout, 3'h0, rb, ra});
    rd(XIO_OFS_OVR_SEL, 16'h0000);
    // release, then every selector code on both relays
    for (int i = 0; i < 10; i++) begin
      ms <= rnd();
      d1 <= rnd();
      d2 <= rnd();
      sp <= rnd();
      wr(XIO_OFS_OVR_SEL, 16'h0000);
      wr(XIO_OFS_SRC_A, {11'h000, codes[i]});
      wr(XIO_OFS_SRC_B, {11'h000, codes[(i + 3) % 10]});
      wr(XIO_OFS_DOUT_CTL, {15'h0000, ms[0]});
      idle(3);
      chk("outputs", {10'h000, ms[0], 3'h0, src(codes[(i + 3) % 10]), src(codes[i])},
        {10'h000, dout, 3'h0, rb, ra});
    end
    // unlisted codes keep the relays off even with every status bit set
    ms <= 16'hFFFF;
    d1 <= 16'hFFFF;
    d2 <= 16'hFFFF;
    sp <= 16'hFFFF;
    wr(XIO_OFS_SRC_A, 16'h0003);
    wr(XIO_OFS_SRC_B, 16'h001F);
    wr(XIO_OFS_DOUT_CTL, 16'h0000);
    idle(3);
    chk("outputs", 16'h0000, {10'h000, dout, 3'h0, rb, ra});
    summarize();
  end
endmodule
bind xio_top xio_top_asserts #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .ext_input_i(ext_input_i), .main_status_i(main_status_i),
  .drive_status1_i(drive_status1_i), .drive_status2_i(drive_status2_i), .speed_status_i(speed_status_i),
  .relay_out_a_o(relay_out_a_o), .relay_out_b_o(relay_out_b_o), .ext_digital_out_o(ext_digital_out_o));
